// ===== hw/edp_map.svh
// register offsets, field positions, reset values and timing counts of the image programmer
// assumes an 8-bit register port with a byte address and a 40 MHz system clock
`ifndef EDP_MAP_SVH
`define EDP_MAP_SVH

`define EDP_OFS_COUNT      8'h10
`define EDP_OFS_ADRUPPER   8'h12
`define EDP_OFS_REVISION   8'h13
`define EDP_OFS_OVERLAY    8'h14
`define EDP_OFS_NVCTRL     8'hAB
`define EDP_OFS_PTRHIGH    8'hAD
`define EDP_OFS_PTRLOW     8'hAE
`define EDP_OFS_DATA       8'hB0
`define EDP_OFS_KEY        8'hB4

`define EDP_BIT_OVERLAY    7
`define EDP_BIT_COMMIT     6
`define EDP_BIT_BUSY       2
`define EDP_BIT_ERASE      1
`define EDP_BIT_PROGRAM    0

`define EDP_KEY_UNLOCK     8'hEA
`define EDP_KEY_LOCK       8'h00
`define EDP_IMG_ADRUPPER   13'h000C
`define EDP_IMG_REVISION   13'h000D
`define EDP_ADRUPPER_MASK  8'hF8
`define EDP_RESET_ADRUPPER 8'hC8
`define EDP_RESET_REVISION 8'h00

`define EDP_CLK_MHZ        40
`define EDP_PROG_TIME_MS   500
`define EDP_PROG_CYCLES    (`EDP_PROG_TIME_MS * 1000 * `EDP_CLK_MHZ)
`define EDP_COMMIT_CYCLES  14'h2000

`endif

// ===== hw/edp_pkg.sv
// types shared by the image programmer and its surroundings
// assumes the constants header for widths of offsets and data
package edp_pkg;

	// one register port access from the serial front end
	typedef struct packed {
		logic       wrStb;
		logic       rdStb;
		logic [7:0] addr;
		logic [7:0] wdata;
	} edp_regreq_type;

	// image engine states
	typedef enum logic [2:0] {
		EDP_IDLE,
		EDP_COMMIT,
		EDP_ERASE,
		EDP_PROGRAM,
		EDP_DONE
	} edp_state_type;

endpackage

// ===== hw/edp_programmer.sv
// non-volatile start-up image programmer: staging sram, unlock key, erase/program engine
// assumes a serial front end that presents one-cycle read and write strobes on clk_sys
// and a power-on reset that doubles as the synchronous reset input
`timescale 1ns/1ps
`include "edp_map.svh"

////////////////////////////////////////////////////////////////////////////////////////////

module edp_programmer #(
	parameter int PROG_CYCLES = `EDP_PROG_CYCLES
) (
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	input  wire edp_pkg::edp_regreq_type regReq,
	output logic [7:0]                   rdData,
	output logic                         rdValid,
	input  wire logic [7:0]              activeRegData,
	output logic [12:0]                  activeRegAddr,
	output logic                         overlayLoad,
	output logic [12:0]                  overlayAddr,
	output logic [7:0]                   overlayData
);
	import edp_pkg::*;

	localparam int DEPTH = 8192;

	// all state of the block apart from the two memories and the sram read register
	typedef struct packed {
		edp_state_type state;
		logic [7:0]    count;
		logic [7:0]    adrUpper;
		logic [7:0]    revision;
		logic          overlayEnable;
		logic          commitBusy;
		logic          imageBusy;
		logic [4:0]    ptrUpper;
		logic [7:0]    ptrLower;
		logic [7:0]    lastData;
		logic [7:0]    key;
		logic          doErase;
		logic          doProgram;
		logic          progDone;
		logic          loading;
		logic [12:0]   walk;
		logic [31:0]   timer;
		logic [13:0]   step;
		logic [13:0]   commitLen;
		logic [7:0]    rdData;
		logic          rdValid;
	} edp_state_all_type;

	edp_state_all_type state_r;
	edp_state_all_type state_nxt;

	// staging sram and non-volatile image
	logic [7:0] staging [DEPTH];
	logic [7:0] image [DEPTH];
	logic [7:0] imageRd;
	logic [7:0] stagingRd;
	logic       stgWe;
	logic [12:0] stgAddr;
	logic [7:0] stgData;
	logic       imgWe;
	logic [7:0] imgData;
	logic       unlocked;
	logic [12:0] pointer;

	assign unlocked = (state_r.key == `EDP_KEY_UNLOCK);
	assign pointer  = {state_r.ptrUpper, state_r.ptrLower};

	////////////////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		state_nxt = state_r;
		state_nxt.rdValid = 1'b0;
		stgWe   = 1'b0;
		stgAddr = pointer;
		stgData = regReq.wdata;
		imgWe   = 1'b0;
		imgData = stagingRd;
		// register writes
		if (regReq.wrStb) begin
			if (regReq.addr == `EDP_OFS_OVERLAY) begin
				state_nxt.overlayEnable = regReq.wdata[`EDP_BIT_OVERLAY];
			end else if (regReq.addr == `EDP_OFS_PTRHIGH) begin
				state_nxt.ptrUpper = regReq.wdata[4:0];
			end else if (regReq.addr == `EDP_OFS_PTRLOW) begin
				state_nxt.ptrLower = regReq.wdata;
			end else if (regReq.addr == `EDP_OFS_DATA) begin
				state_nxt.lastData = regReq.wdata;
				if (state_r.state != EDP_COMMIT) begin
					stgWe = 1'b1;
				end
			end else if (regReq.addr == `EDP_OFS_KEY) begin
				state_nxt.key = regReq.wdata;
			end else if (regReq.addr == `EDP_OFS_NVCTRL && state_r.state == EDP_IDLE) begin
				if (regReq.wdata[`EDP_BIT_COMMIT]) begin
					state_nxt.commitBusy = 1'b1;
					state_nxt.walk = 13'h0000;
					state_nxt.state = EDP_COMMIT;
				end else if (unlocked && (regReq.wdata[`EDP_BIT_ERASE] ||
					regReq.wdata[`EDP_BIT_PROGRAM])) begin
					state_nxt.doErase = regReq.wdata[`EDP_BIT_ERASE];
					state_nxt.doProgram = regReq.wdata[`EDP_BIT_PROGRAM];
					state_nxt.imageBusy = 1'b1;
					state_nxt.walk = 13'h0000;
					state_nxt.timer = 32'h0000_0000;
					state_nxt.step = 14'h0000;
					state_nxt.state = regReq.wdata[`EDP_BIT_ERASE] ? EDP_ERASE : EDP_PROGRAM;
				end // locked requests fall through unchanged
			end
		end
		// register reads
		if (regReq.rdStb) begin
			state_nxt.rdValid = 1'b1;
			if (regReq.addr == `EDP_OFS_COUNT) begin
				state_nxt.rdData = state_r.count;
			end else if (regReq.addr == `EDP_OFS_ADRUPPER) begin
				state_nxt.rdData = state_r.adrUpper;
			end else if (regReq.addr == `EDP_OFS_REVISION) begin
				state_nxt.rdData = state_r.revision;
			end else if (regReq.addr == `EDP_OFS_OVERLAY) begin
				state_nxt.rdData = {state_r.overlayEnable, 7'h00};
			end else if (regReq.addr == `EDP_OFS_NVCTRL) begin
				state_nxt.rdData = {1'b0, state_r.commitBusy, 3'h0, state_r.imageBusy, 2'h0};
			end else if (regReq.addr == `EDP_OFS_PTRHIGH) begin
				state_nxt.rdData = {3'h0, state_r.ptrUpper};
			end else if (regReq.addr == `EDP_OFS_PTRLOW) begin
				state_nxt.rdData = state_r.ptrLower;
			end else if (regReq.addr == `EDP_OFS_DATA) begin
				state_nxt.rdData = state_r.lastData;
			end else if (regReq.addr == `EDP_OFS_KEY) begin
				state_nxt.rdData = state_r.key;
			end else begin
				state_nxt.rdData = 8'h00;
			end
		end
		// image engine
		case (state_r.state)
			EDP_COMMIT: begin
				// the two user bytes are never overwritten by the commit path
				stgAddr = state_r.walk;
				stgData = activeRegData;
				stgWe = (state_r.walk != `EDP_IMG_ADRUPPER) &&
					(state_r.walk != `EDP_IMG_REVISION);
				state_nxt.walk = state_r.walk + 13'h0001;
				if (state_r.walk == 13'h1FFF) begin
					state_nxt.commitBusy = 1'b0;
					state_nxt.state = EDP_IDLE;
				end
			end
			EDP_ERASE: begin
				imgWe = 1'b1;
				imgData = 8'h00;
				state_nxt.walk = state_r.walk + 13'h0001;
				if (state_r.walk == 13'h1FFF) begin
					state_nxt.state = state_r.doProgram ? EDP_PROGRAM : EDP_DONE;
					state_nxt.step = 14'h0000; // walk wraps to zero by itself
				end
			end
			EDP_PROGRAM: begin
				// own step count: the busy timer already ran on through the erase walk
				imgWe = (state_r.step != 14'h0000) &&
					(state_r.step <= 14'(DEPTH));
				if (state_r.step < 14'(DEPTH)) begin
					state_nxt.walk = state_r.walk + 13'h0001;
				end
				state_nxt.step = state_r.step + 14'h0001;
				if (state_r.step >= 14'(DEPTH)) begin
					state_nxt.state = EDP_DONE;
				end
			end
			EDP_DONE: begin
				// hold busy for the full programming time
				if (state_r.timer >= 32'(PROG_CYCLES - 1)) begin
					state_nxt.imageBusy = 1'b0;
					state_nxt.progDone = state_r.doProgram;
					state_nxt.state = EDP_IDLE;
				end
			end
			default: begin
			end
		endcase
		if (state_r.imageBusy) begin
			state_nxt.timer = state_r.timer + 32'h0000_0001;
		end
		// length of the running copy, watched by the commit checks
		state_nxt.commitLen = state_r.commitBusy ? state_r.commitLen + 14'h0001 : 14'h0000;
		// power-on load: mirrors and overlay come from the image
		if (state_r.loading) begin
			state_nxt.walk = state_r.walk + 13'h0001;
			if (state_r.walk == 13'h1FFF) begin
				state_nxt.loading = 1'b0;
			end
		end
	end

	// address used by the programming walk for the image write
	logic [12:0] imgAddr;
	assign imgAddr = (state_r.state == EDP_PROGRAM) ? state_r.walk - 13'h0001 : state_r.walk;

	////////////////////////////////////////////////////////////////////////////////////////
	// state register; reset acts as the power-on reset and starts the image load
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_r <= '0;
			state_r.state <= EDP_IDLE;
			state_r.adrUpper <= `EDP_RESET_ADRUPPER;
			state_r.revision <= `EDP_RESET_REVISION;
			state_r.loading <= 1'b1;
			state_r.overlayEnable <= state_r.overlayEnable; // must survive the reset
			if (state_r.progDone) begin
				state_r.count <= state_r.count + 8'h01;
			end else begin
				state_r.count <= state_r.count;
			end
		end else begin
			state_r <= state_nxt;
			if (state_r.loading && state_r.walk == `EDP_IMG_ADRUPPER) begin
				state_r.adrUpper <= imageRd & `EDP_ADRUPPER_MASK;
			end
			if (state_r.loading && state_r.walk == `EDP_IMG_REVISION) begin
				state_r.revision <= imageRd;
			end
		end
	end

	// memories
	always_ff @(posedge clk_sys) begin
		if (stgWe) begin
			staging[stgAddr] <= stgData;
		end
		if (imgWe) begin
			image[imgAddr] <= imgData;
		end
		stagingRd <= staging[state_r.walk];
	end

	// combinational image read for the power-on load walk
	assign imageRd = image[state_r.walk];

	////////////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign rdData        = state_r.rdData;
	assign rdValid       = state_r.rdValid;
	assign activeRegAddr = state_r.walk;
	assign overlayLoad   = state_r.loading && state_r.overlayEnable == 1'b0 ? 1'b0 :
		state_r.loading;
	assign overlayAddr   = state_r.walk;
	assign overlayData   = imageRd;

	////////////////////////////////////////////////////////////////////////////////////////
	// checks
	a_commit_clears: assert property (@(posedge clk_sys) disable iff (reset)
		state_r.commitBusy |-> state_r.commitLen < `EDP_COMMIT_CYCLES)
		else $error("commit bit did not clear after the copy");
	a_commit_length: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(state_r.commitBusy) |-> state_r.commitLen == `EDP_COMMIT_CYCLES)
		else $error("commit walk length wrong");
	a_locked_ignored: assert property (@(posedge clk_sys) disable iff (reset)
		(regReq.wrStb && regReq.addr == `EDP_OFS_NVCTRL && !unlocked && !state_r.imageBusy)
		|=> !state_r.imageBusy)
		else $error("locked request started programming");
	a_busy_rises: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(state_r.imageBusy) |-> $past(unlocked))
		else $error("busy set without unlock");
	a_data_write: assert property (@(posedge clk_sys) disable iff (reset)
		(regReq.wrStb && regReq.addr == `EDP_OFS_DATA && state_r.state != EDP_COMMIT)
		|-> stgWe && stgAddr == pointer)
		else $error("data write missed the sram");
	a_ptr_high: assert property (@(posedge clk_sys) disable iff (reset)
		(regReq.wrStb && regReq.addr == `EDP_OFS_PTRHIGH) |=> pointer[12:8] == $past(regReq.wdata[4:0]))
		else $error("pointer high not taken");
	a_ptr_low: assert property (@(posedge clk_sys) disable iff (reset)
		(regReq.wrStb && regReq.addr == `EDP_OFS_PTRLOW) |=> pointer[7:0] == $past(regReq.wdata))
		else $error("pointer low not taken");
	a_user_bytes_kept: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r.state == EDP_COMMIT && (stgAddr == `EDP_IMG_ADRUPPER ||
			stgAddr == `EDP_IMG_REVISION)) |-> !stgWe)
		else $error("commit touched a user byte");
	a_busy_length: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(state_r.imageBusy) |-> $past(state_r.timer) >= 32'(PROG_CYCLES - 1))
		else $error("busy cleared early");
	a_erase_zero: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r.state == EDP_ERASE) |-> imgWe && imgData == 8'h00)
		else $error("erase wrote nonzero");
	a_mirror_mask: assert property (@(posedge clk_sys) disable iff (reset)
		state_r.adrUpper[2:0] == 3'h0)
		else $error("address mirror low bits set");

	// unlock then start, as two register writes in a row
	sequence s_unlock_write;
		regReq.wrStb && regReq.addr == `EDP_OFS_KEY && regReq.wdata == `EDP_KEY_UNLOCK;
	endsequence
	sequence s_start_write;
		regReq.wrStb && regReq.addr == `EDP_OFS_NVCTRL && regReq.wdata[1:0] != 2'h0 &&
			!regReq.wdata[`EDP_BIT_COMMIT] && state_r.state == EDP_IDLE;
	endsequence

	a_unlock_start: assert property (@(posedge clk_sys) disable iff (reset)
		s_unlock_write ##1 s_start_write |=> state_r.imageBusy)
		else $error("unlocked request did not start programming");
	a_relock_key: assert property (@(posedge clk_sys) disable iff (reset)
		(regReq.wrStb && regReq.addr == `EDP_OFS_KEY && regReq.wdata == `EDP_KEY_LOCK)
		|=> !unlocked)
		else $error("zero key did not relock");
	a_mirror_read: assert property (@(posedge clk_sys) disable iff (reset)
		(regReq.rdStb && regReq.addr == `EDP_OFS_ADRUPPER)
		|=> rdValid && rdData == $past(state_r.adrUpper))
		else $error("address mirror read wrong");
	a_revision_read: assert property (@(posedge clk_sys) disable iff (reset)
		(regReq.rdStb && regReq.addr == `EDP_OFS_REVISION)
		|=> rdValid && rdData == $past(state_r.revision))
		else $error("revision mirror read wrong");
	a_key_read: assert property (@(posedge clk_sys) disable iff (reset)
		(regReq.rdStb && regReq.addr == `EDP_OFS_KEY) |=> rdData == $past(state_r.key))
		else $error("key read wrong");
	a_erase_to_program: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r.state == EDP_ERASE && state_r.walk == 13'h1FFF && state_r.doProgram)
		|=> (state_r.state == EDP_PROGRAM && state_r.walk == 13'h0000 &&
			state_r.step == 14'h0000))
		else $error("program walk did not follow erase");
	a_program_trail: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r.state == EDP_PROGRAM && state_r.step == 14'h0000) |-> !imgWe)
		else $error("image written before sram data was read");
	a_program_last: assert property (@(posedge clk_sys) disable iff (reset)
		(state_r.state == EDP_PROGRAM && state_r.step == 14'h2000)
		|-> imgWe && imgAddr == 13'h1FFF)
		else $error("last image byte not written");
	a_load_done: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(state_r.loading) |-> $past(state_r.walk) == 13'h1FFF)
		else $error("load walk ended early");
endmodule

// ===== test/edp_programmer_tb.sv
// testbench for the image programmer: register port scenarios, staging writes, program cycle
// assumes the map header and package are compiled first; program time is shortened by parameter
`timescale 1ns/1ps
`include "edp_map.svh"

////////////////////////////////////////////////////////////////////////////////////////////

module testbench;
	import edp_pkg::*;

	localparam int PROG = 20000;
	localparam int WALK = 8300;

	logic           clk_sys;
	logic           reset;
	edp_regreq_type regReq;
	logic [7:0]     rdData;
	logic           rdValid;
	logic [7:0]     activeRegData;
	logic [12:0]    activeRegAddr;
	logic           overlayLoad;
	logic [12:0]    overlayAddr;
	logic [7:0]     overlayData;
	int             miscompares;
	int             check_count;
	logic [7:0]     rv;
	logic [7:0]     cnt0;

	// free-running system clock, 25 ns period
	initial clk_sys = 1'b0;
	always #12.5 clk_sys = ~clk_sys;

	// active register contents seen by the commit walk
	assign activeRegData = activeRegAddr[7:0] ^ 8'hA5;

	edp_programmer #(
		.PROG_CYCLES (PROG)
	) i_dut (
		.clk_sys       (clk_sys),
		.reset         (reset),
		.regReq        (regReq),
		.rdData        (rdData),
		.rdValid       (rdValid),
		.activeRegData (activeRegData),
		.activeRegAddr (activeRegAddr),
		.overlayLoad   (overlayLoad),
		.overlayAddr   (overlayAddr),
		.overlayData   (overlayData)
	);

	////////////////////////////////////////////////////////////////////////////////////////

	// verdict and end of run
	task automatic finish_test();
		$display("miscompares %0d check_count %0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// byte comparison
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// start a write strobe, held one cycle
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		regReq <= '{wrStb: 1'b1, rdStb: 1'b0, addr: a, wdata: d};
	endtask

	// release both strobes
	task automatic idle();
		@(negedge clk_sys);
		regReq.wrStb <= 1'b0;
		regReq.rdStb <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		put(a, d);
		idle();
	endtask

	// read with a bounded wait for the answer pulse
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		int n;
		n = 0;
		@(negedge clk_sys);
		regReq <= '{wrStb: 1'b0, rdStb: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_sys);
		regReq.rdStb <= 1'b0;
		while (rdValid !== 1'b1 && n < 4) begin
			@(negedge clk_sys);
			n++;
		end
		if (rdValid !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED at %0t: read answer got %h expected %h", $time, rdValid, 1'b1);
		end
		q = rdData;
	endtask

	// poll the control register until the masked bits drop
	task automatic wait_clear(input logic [7:0] mask, input int bound);
		int n;
		n = 0;
		rd(`EDP_OFS_NVCTRL, rv);
		while ((rv & mask) !== 8'h00 && n < bound) begin
			rd(`EDP_OFS_NVCTRL, rv);
			n++;
		end
		chk(rv & mask, 8'h00);
	endtask

	// power-on reset, then let the load walk run out
	task automatic do_reset();
		@(negedge clk_sys);
		reset <= 1'b1;
		repeat (10) @(negedge clk_sys);
		reset <= 1'b0;
		repeat (WALK) @(negedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////////////////////

	// unmapped read, wrong key and missing key leave the engine idle
	task automatic scen_locked();
		rd(8'h55, rv);
		chk(rv, 8'h00);
		wr(`EDP_OFS_KEY, 8'hE9);
		wr(`EDP_OFS_NVCTRL, 8'h03);
		rd(`EDP_OFS_NVCTRL, rv);
		chk(rv & 8'h04, 8'h00);
		wr(`EDP_OFS_KEY, `EDP_KEY_LOCK);
		wr(`EDP_OFS_NVCTRL, 8'h03);
		rd(`EDP_OFS_NVCTRL, rv);
		chk(rv & 8'h04, 8'h00);
	endtask

	// direct writes of the address and revision bytes, then commit, then a far byte
	task automatic scen_staging();
		wr(`EDP_OFS_PTRHIGH, 8'h00);
		wr(`EDP_OFS_PTRLOW, 8'h0C);
		wr(`EDP_OFS_DATA, 8'h98);
		wr(`EDP_OFS_PTRLOW, 8'h0D);
		wr(`EDP_OFS_DATA, 8'h5A);
		rd(`EDP_OFS_PTRLOW, rv);
		chk(rv, 8'h0D);
		rd(`EDP_OFS_DATA, rv);
		chk(rv, 8'h5A);
		wr(`EDP_OFS_NVCTRL, 8'h40);
		rd(`EDP_OFS_NVCTRL, rv);
		chk(rv & 8'h40, 8'h40);
		wait_clear(8'h40, 6000);
		wr(`EDP_OFS_PTRHIGH, 8'h1F);
		wr(`EDP_OFS_PTRLOW, 8'hFF);
		wr(`EDP_OFS_DATA, 8'h77);
		rd(`EDP_OFS_PTRHIGH, rv);
		chk(rv & 8'h1F, 8'h1F);
		wr(`EDP_OFS_OVERLAY, 8'h80);
		rd(`EDP_OFS_OVERLAY, rv);
		chk(rv & 8'h80, 8'h80);
	endtask

	// unlock and program back to back, busy span, relock, then reset effects
	task automatic scen_program();
		rd(`EDP_OFS_COUNT, cnt0);
		put(`EDP_OFS_KEY, `EDP_KEY_UNLOCK);
		put(`EDP_OFS_NVCTRL, 8'h03);
		idle();
		rd(`EDP_OFS_NVCTRL, rv);
		chk(rv & 8'h04, 8'h04);
		repeat (5000) @(negedge clk_sys);
		rd(`EDP_OFS_NVCTRL, rv);
		chk(rv & 8'h04, 8'h04);
		wait_clear(8'h04, 12000);
		rd(`EDP_OFS_KEY, rv);
		chk(rv, `EDP_KEY_UNLOCK);
		wr(`EDP_OFS_KEY, `EDP_KEY_LOCK);
		wr(`EDP_OFS_NVCTRL, 8'h03);
		rd(`EDP_OFS_NVCTRL, rv);
		chk(rv & 8'h04, 8'h00);
		do_reset();
		rd(`EDP_OFS_COUNT, rv);
		chk(rv, cnt0 + 8'h01);
		rd(`EDP_OFS_ADRUPPER, rv);
		chk(rv, 8'h98);
		rd(`EDP_OFS_REVISION, rv);
		chk(rv, 8'h5A);
	endtask

	// image bytes offered while the overlay load walk runs
	always @(negedge clk_sys) begin
		if (overlayLoad === 1'b1) begin
			if (overlayAddr === 13'h0005) chk(overlayData, 8'hA0);
			if (overlayAddr === 13'h1FFF) chk(overlayData, 8'h77);
			if (overlayAddr === 13'h000C) chk(overlayData, 8'h98);
			if (overlayAddr === 13'h000D) chk(overlayData, 8'h5A);
		end
	end

	// watchdog sized well past the expected run of about 45k cycles
	initial begin
		#2500000;
		miscompares++;
		$display("CHECK FAILED at %0t: watchdog expired %h %h", $time, 8'h00, 8'h01);
		finish_test();
	end

	// main sequence
	initial begin
		miscompares = 0;
		check_count = 0;
		reset = 1'b1;
		regReq = '0;
		do_reset();
		scen_locked();
		scen_staging();
		scen_program();
		finish_test();
	end

endmodule
